// *** bench/ee_model.sv ***
// Purpose: Configuration memory answering the loader's byte reads
// Assumes: Reads are answered only at address byte 8'ha0
// Notes:   Data bytes follow the byte address; blank gives an 8'hff header
module ee_model (
  // Clock and request
  input wire sys_clk,
  input wire ee_req,
  input wire [7:0] ee_dev_addr,
  input wire [9:0] ee_addr,
  // Bench controls
  input wire blank,
  input wire [1:0] wait_cyc,
  // Answer
  output reg ee_valid,
  output reg [7:0] ee_data
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] cnt_q = 2'h0;
  initial ee_valid = 1'b0;
  initial ee_data = 8'h00;
  always @(posedge sys_clk) begin
    ee_valid <= 1'b0;
    // Idle data flips so no stale byte looks valid
    ee_data <= ~ee_data;
    if (ee_req && !ee_valid && ee_dev_addr == 8'ha0) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == wait_cyc) begin
        cnt_q <= 2'h0;
        ee_valid <= 1'b1;
        if (ee_addr == 10'h000)
          ee_data <= blank ? 8'hff : 8'h01;
        else
          ee_data <= {1'b0, 3'h1 + ee_addr[1:0], 2'h0, ee_addr[1:0]};
      end
    end
  end
endmodule // ee_model

// *** bench/repeater_mode_and_config_control_test.sv ***
// Purpose: Self-checking bench for the repeater mode control
// Assumes: Probe period 20, three tries, power-down reset 5 cycles
// Notes:   Pin codes sit mid-band: 8'h10, 8'h58, 8'ha0, 8'he8
`include "repeater_ctl_map.vh"
module repeater_mode_and_config_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  reg sys_clk = 1'b0, rst_b = 1'b0, power_down_pin = 1'b0, cfg_wr = 1'b0;
  reg reg_enable = 1'b0, term_override = 1'b0, sdth_override = 1'b0;
  reg presence_override = 1'b0, presence_value = 1'b0, blank = 1'b0;
  reg cfg_term_dis = 1'b0, load_permit_b = 1'b1;
  reg [7:0] mode_select_pin = 8'h00, group_a_equalizer_pin = 8'h00;
  reg [7:0] group_b_equalizer_pin = 8'h00, termination_detect_pin = 8'h00;
  reg [7:0] signal_detect_threshold_pin = 8'h00, rx_far_end_seen = 8'h00;
  reg [7:0] signal_detect_in = 8'h00;
  reg [15:0] group_a_swing_pins = 16'h0000, group_b_swing_pins = 16'h0000;
  reg [1:0] term_code = 2'h0, sdth_code = 2'h0, cfg_eq = 2'h0;
  reg [1:0] wait_cyc = 2'h0;
  reg [2:0] cfg_chan = 3'h0, cfg_swing = 3'h0;
  reg [15:0] ee_eq;
  reg [23:0] ee_sw;
  wire ee_valid, ee_req, load_done, bus_master_active, bus_slave_enable;
  wire rx_probe;
  wire [7:0] ee_data, ee_dev_addr, slave_addr, term_50_en, driver_en;
  wire [7:0] signal_detect_status;
  wire [9:0] ee_addr;
  wire [15:0] eq_out;
  wire [23:0] swing_out;
  wire [1:0] sdth_out, mode_out;
  integer err_count = 0, tests_run = 0, i, n;

  repeater_mode_ctl #(.PROBE_CYC(20), .PROBE_TRIES(3), .PDRST_CYC(5))
    i_dut (.*);
  ee_model i_ee (.*);

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task cyc(input integer k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask

  task chk(input [31:0] nm, input [23:0] e, input [23:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("mismatch %0s exp %h got %h", nm, e, g);
    end
  endtask

  task count_probes(input integer k);
    n = 0;
    repeat (k) begin
      cyc(1);
      if (rx_probe === 1'b1) n = n + 1;
    end
  endtask

  task wr_cfg;
    cfg_chan = 3'h1;
    cfg_eq = 2'h3;
    cfg_swing = 3'h3;
    cfg_term_dis = 1'b1;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(3);
  endtask

  task t_reset;
    cyc(12);
    chk("eq", {8{`EQ_DEFAULT}}, eq_out);
    chk("addr", `SLAVE_ADDR_BASE, slave_addr);
    rst_b = 1'b1;
    cyc(2);
  endtask

  task t_pin;
    group_a_equalizer_pin = 8'h58;
    group_b_equalizer_pin = 8'he8;
    group_a_swing_pins = 16'he810;
    group_b_swing_pins = 16'h1058;
    signal_detect_in = 8'h5a;
    cyc(4);
    chk("eq", {{4{2'h3}}, {4{2'h1}}}, eq_out);
    chk("sw", {{4{3'h2}}, {4{3'h6}}}, swing_out);
    chk("sds", 8'h5a, signal_detect_status);
    for (i = 0; i < 4; i = i + 1) begin
      signal_detect_threshold_pin = 8'h10 + 8'h48 * i;
      termination_detect_pin = signal_detect_threshold_pin;
      cyc(4);
      chk("sdt", (8'hc6 >> (2 * i)) & 8'h3, sdth_out);
      chk("t50", (i == 3) ? 8'hff : 8'h00, term_50_en);
    end
  endtask

  task t_slave;
    mode_select_pin = 8'hff;
    group_a_equalizer_pin = 8'ha0;
    group_b_equalizer_pin = 8'h00;
    group_a_swing_pins = 16'h0000;
    group_b_swing_pins = 16'h0000;
    cyc(4);
    chk("eq", {8{`EQ_DEFAULT}}, eq_out);
    chk("sw", {8{`SWING_DEFAULT}}, swing_out);
    chk("addr", 8'hb2, slave_addr);
    wr_cfg;
    chk("eq", {8{`EQ_DEFAULT}}, eq_out);
    reg_enable = 1'b1;
    wr_cfg;
    chk("eq", 16'haaae, eq_out);
    chk("sw", {{6{3'h6}}, 3'h3, 3'h6}, swing_out);
    power_down_pin = 1'b1;
    cyc(8);
    power_down_pin = 1'b0;
    cyc(3);
    chk("eq", 16'haaae, eq_out);
    term_override = 1'b1;
    term_code = 2'h3;
    termination_detect_pin = 8'h00;
    sdth_override = 1'b1;
    sdth_code = 2'h1;
    signal_detect_threshold_pin = 8'h10;
    cyc(4);
    chk("t50", 8'hfd, term_50_en);
    chk("sdt", 2'h1, sdth_out);
    term_override = 1'b0;
    cyc(4);
    chk("t50", 8'hfd, term_50_en);
    mode_select_pin = 8'h00;
    cyc(4);
    chk("t50", 8'h00, term_50_en);
  endtask

  task t_termination_detect_pin;
    termination_detect_pin = 8'ha0;
    power_down_pin = 1'b1;
    cyc(8);
    power_down_pin = 1'b0;
    count_probes(110);
    chk("prb", 5, n);
    rx_far_end_seen = 8'h0f;
    cyc(1);
    rx_far_end_seen = 8'h00;
    cyc(3);
    chk("t50", 8'h0f, term_50_en);
    termination_detect_pin = 8'h58;
    power_down_pin = 1'b1;
    cyc(8);
    power_down_pin = 1'b0;
    count_probes(200);
    chk("prb", 3, n);
    mode_select_pin = 8'hff;
    presence_override = 1'b1;
    cyc(120);
    presence_value = 1'b1;
    count_probes(200);
    chk("prb", 3, n);
  endtask

  task t_load;
    mode_select_pin = 8'h80;
    wait_cyc = 2'h2;
    group_a_equalizer_pin = 8'h00;
    cyc(10);
    chk("req", 1'b0, ee_req);
    load_permit_b = 1'b0;
    n = 0;
    while (load_done !== 1'b1 && n < 300) begin
      cyc(1);
      n = n + 1;
    end
    chk("done", 1'b1, load_done);
    cyc(2);
    for (i = 0; i < 8; i = i + 1) begin
      ee_eq[2*i +: 2] = (3 + i) & 3;
      ee_sw[3*i +: 3] = 1 + ((3 + i) & 3);
    end
    chk("eq", ee_eq, eq_out);
    chk("sw", ee_sw, swing_out);
    chk("mode", 2'h1, mode_out);
    chk("bus", 2'h1, {bus_master_active, bus_slave_enable});
  endtask

  task t_stall;
    rst_b = 1'b0;
    blank = 1'b1;
    wait_cyc = 2'h0;
    cyc(2);
    rst_b = 1'b1;
    cyc(60);
    chk("bus", 2'h2, {bus_master_active, bus_slave_enable});
    chk("done", 1'b0, load_done);
    mode_select_pin = 8'hff;
    cyc(3);
    chk("bus", 2'h2, {bus_master_active, bus_slave_enable});
  endtask

  task report_and_stop;
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #150000;
    err_count = err_count + 1;
    report_and_stop;
  end

  initial begin
    t_reset;
    t_pin;
    t_slave;
    t_termination_detect_pin;
    t_load;
    t_stall;
    report_and_stop;
  end
endmodule // repeater_mode_and_config_control_test

// *** bench/repeater_mode_ctl_props.sv ***
// Purpose: Port assertions for the repeater mode control
// Assumes: Four-level bands split at 8'h33, 8'h80 and 8'hcc
// Notes:   Attached to every instance by the bind below
module repeater_mode_ctl_props (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Pins
  input wire [7:0] mode_select_pin,
  input wire [7:0] termination_detect_pin,
  input wire [7:0] signal_detect_threshold_pin,
  input wire power_down_pin,
  // Outputs
  input wire [7:0] ee_dev_addr,
  input wire bus_master_active,
  input wire bus_slave_enable,
  input wire [7:0] term_50_en,
  input wire [7:0] driver_en,
  input wire [1:0] sdth_out,
  input wire [1:0] mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  wire pin_m = mode_select_pin < 8'h33;
  wire live = pin_m && !power_down_pin;
  sequence s_pin_hiz;
    (live && termination_detect_pin < 8'h33) [*3];
  endsequence
  sequence s_pin_50;
    (live && termination_detect_pin >= 8'hcc) [*3];
  endsequence
  chk_mode_pin: assert property (
    pin_m |=> mode_out == 2'h0) else $error("mode not pin");
  chk_mode_slave: assert property (
    mode_select_pin >= 8'hcc |=> mode_out == 2'h1)
    else $error("mode not slave");
  chk_pd_off: assert property (
    power_down_pin |=> driver_en == 8'h00 && term_50_en == 8'h00)
    else $error("power-down left channel on");
  chk_drv_on: assert property (
    !power_down_pin |=> driver_en == 8'hff) else $error("driver off");
  chk_term_hiz: assert property (
    s_pin_hiz |=> term_50_en == 8'h00) else $error("term not hi-z");
  chk_term_50: assert property (
    s_pin_50 |=> term_50_en == 8'hff) else $error("term not 50 ohm");
  chk_sdth_pin: assert property (
    (pin_m && signal_detect_threshold_pin < 8'h33) [*3]
    |=> sdth_out == 2'h2) else $error("threshold code wrong");
  chk_ee_addr: assert property (
    ee_dev_addr == 8'ha0) else $error("memory address byte wrong");
  chk_stall_lock: assert property (
    bus_master_active |-> !bus_slave_enable) else $error("bus shared");
endmodule // repeater_mode_ctl_props

bind repeater_mode_ctl repeater_mode_ctl_props i_props (.*);

// *** inc/repeater_ctl_map.vh ***
// Purpose: Named constants for the repeater mode and configuration control
// Assumes: 40 MHz sys_clk; four-level pins sampled as 8-bit voltage codes
// Notes:   Codes are fractions of full scale 8'hff
`ifndef REPEATER_CTL_MAP_VH
`define REPEATER_CTL_MAP_VH
// Four-level thresholds (0.2, 0.5, 0.8 of supply on an 8-bit scale)
`define LVL_TH_0R 8'h33
`define LVL_TH_RF 8'h80
`define LVL_TH_F1 8'hcc
// Decoded levels
`define LVL_0 2'h0
`define LVL_R 2'h1
`define LVL_F 2'h2
`define LVL_1 2'h3
// Termination codes
`define TERM_HIZ 2'h0
`define TERM_AUTO_LIM 2'h1
`define TERM_AUTO 2'h2
`define TERM_50 2'h3
// Signal-detect threshold codes
`define SDTH_FROM_0 2'h2
`define SDTH_FROM_R 2'h1
`define SDTH_FROM_F 2'h0
`define SDTH_FROM_1 2'h3
// Register defaults
`define EQ_DEFAULT 2'h2
`define SWING_DEFAULT 3'h6
// Swing levels
`define SWING_L1 3'h1
`define SWING_L2 3'h2
`define SWING_L3 3'h3
`define SWING_L4 3'h4
`define SWING_L5 3'h5
`define SWING_L6 3'h6
// Bus address byte base and EEPROM address byte
`define SLAVE_ADDR_BASE 8'hb0
`define EEPROM_ADDR_BYTE 8'ha0
// EEPROM layout: header byte, first device data byte, stride per device
`define EE_HDR_ADDR 10'h000
`define EE_DATA_BASE 10'h003
`define EE_DEV_STRIDE 10'h025
`define EE_BLANK 8'hff
// Timing
`define CLK_HZ 40000000
`define PROBE_MS 12
`define LIMIT_MS 600
`define PDRST_NS 5000
`endif

// *** verilog/repeater_mode_ctl.v ***
// Purpose: Mode selection, pin decoding, register overrides, receiver
//          detect sequencing and EEPROM configuration load for 8 channels
// Assumes: All inputs synchronous to sys_clk; register bits held outside
//          arrive as levels, per-channel writes as a strobe
// Notes:   Channels 0-3 form group A, channels 4-7 group B
`include "repeater_ctl_map.vh"

// Notes on behaviour
// RQ1 - Mode pin low is pin mode, high is slave mode, floating is master load.
// RQ2 - Four-level pins decode to 0, R, F, 1 at 0.2, 0.5, 0.8 of supply.
// RQ3 - Pin mode applies pin equalizer and swing to each channel group.
// RQ4 - Slave mode sets swing, equalizer, termination disable per channel.
// RQ5 - Entering slave mode takes equalizer and swing from registers at once.
// RQ6 - Registers keep defaults until the register-enable bit is set.
// RQ7 - In slave mode equalizer and swing pins become four address inputs.
// RQ8 - Termination and threshold pins rule unless register override is set.
// RQ9 - An overridden pin stays ignored until the mode pin returns low.
// RQ10 - Power-down leaves every register setting unchanged.
// RQ11 - Termination code 00 holds inputs high impedance.
// RQ12 - Code 01 probes every 12 ms for 600 ms, 50 ohm once detected.
// RQ13 - Code 10 probes every 12 ms without limit, 50 ohm once detected.
// RQ14 - Code 11 forces 50 ohm termination.
// RQ15 - Power-down high makes inputs high impedance and disables drivers.
// RQ16 - Power-down held high 5 us resets the receiver-detect machine.
// RQ17 - Toggling presence value under presence override resets the machine.
// RQ18 - Threshold pin levels 0, R, F, 1 map to codes 10, 01, 00, 11.
// RQ19 - Signal-detect status never disables the output driver.
// RQ20 - Signal-detect status stays readable in every mode.
// RQ21 - Master mode loads this device's settings from EEPROM by address.
// RQ22 - After a good load return to slave mode and release the bus.
// RQ23 - A failed load stalls forever with no bus access.
// RQ24 - Address byte is 0xB0 plus twice the four address inputs.
// RQ25 - The EEPROM answers at address byte 0xA0.
// RQ26 - Load-permit input and load-done output chain devices on the EEPROM.
module repeater_mode_ctl #(
  parameter NCH = 8,
  parameter PROBE_CYC = (`CLK_HZ / 1000) * `PROBE_MS,
  parameter PROBE_TRIES = `LIMIT_MS / `PROBE_MS,
  parameter PDRST_CYC = (`CLK_HZ / 1000000) * `PDRST_NS / 1000
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Four-level pins as 8-bit voltage codes, power-down as a one-bit level
  input wire [7:0] mode_select_pin,
  input wire [7:0] group_a_equalizer_pin,
  input wire [7:0] group_b_equalizer_pin,
  input wire [15:0] group_a_swing_pins,
  input wire [15:0] group_b_swing_pins,
  input wire [7:0] termination_detect_pin,
  input wire [7:0] signal_detect_threshold_pin,
  input wire power_down_pin,
  // Register bits held by the bus slave
  input wire reg_enable,
  input wire term_override,
  input wire [1:0] term_code,
  input wire sdth_override,
  input wire [1:0] sdth_code,
  input wire presence_override,
  input wire presence_value,
  // Per-channel register write
  input wire cfg_wr,
  input wire [2:0] cfg_chan,
  input wire [1:0] cfg_eq,
  input wire [2:0] cfg_swing,
  input wire cfg_term_dis,
  // Analog channel status
  input wire [NCH-1:0] rx_far_end_seen,
  input wire [NCH-1:0] signal_detect_in,
  // EEPROM read port and load chain
  input wire load_permit_b,
  output reg load_done,
  output reg ee_req,
  output reg [7:0] ee_dev_addr,
  output reg [9:0] ee_addr,
  input wire ee_valid,
  input wire [7:0] ee_data,
  output reg bus_master_active,
  output reg bus_slave_enable,
  // Channel controls
  output reg [2*NCH-1:0] eq_out,
  output reg [3*NCH-1:0] swing_out,
  output reg [NCH-1:0] term_50_en,
  output reg [NCH-1:0] driver_en,
  output reg rx_probe,
  output reg [1:0] sdth_out,
  output reg [NCH-1:0] signal_detect_status,
  output reg [7:0] slave_addr,
  output reg [1:0] mode_out
);

  localparam M_PIN = 2'h0;
  localparam M_SLAVE = 2'h1;
  localparam M_MASTER = 2'h2;
  // Loader states, one-hot
  localparam L_IDLE = 5'h01;
  localparam L_HDR = 5'h02;
  localparam L_DATA = 5'h04;
  localparam L_DONE = 5'h08;
  localparam L_STALL = 5'h10;
  // Receiver-detect states, one-hot
  localparam D_WAIT = 3'h1;
  localparam D_DONE = 3'h2;
  localparam D_STOP = 3'h4;

  function [1:0] lvl4;
    input [7:0] v;
    begin
      if (v < `LVL_TH_0R) lvl4 = `LVL_0;
      else if (v < `LVL_TH_RF) lvl4 = `LVL_R;
      else if (v < `LVL_TH_F1) lvl4 = `LVL_F;
      else lvl4 = `LVL_1;
    end
  endfunction

  function [2:0] swing_lvl;
    input [1:0] hi;
    input [1:0] lo;
    begin
      case ({hi, lo})
        {`LVL_0, `LVL_0}: swing_lvl = `SWING_L1;
        {`LVL_0, `LVL_R}: swing_lvl = `SWING_L2;
        {`LVL_0, `LVL_1}: swing_lvl = `SWING_L3;
        {`LVL_R, `LVL_F}: swing_lvl = `SWING_L4;
        {`LVL_F, `LVL_R}: swing_lvl = `SWING_L5;
        default: swing_lvl = `SWING_L6;
      endcase
    end
  endfunction

  // Pin decoding
  wire [1:0] mode_lvl = lvl4(mode_select_pin); // RQ2
  wire [1:0] eqa_lvl = lvl4(group_a_equalizer_pin);
  wire [1:0] eqb_lvl = lvl4(group_b_equalizer_pin);
  wire [1:0] va1 = lvl4(group_a_swing_pins[15:8]);
  wire [1:0] va0 = lvl4(group_a_swing_pins[7:0]);
  wire [1:0] vb1 = lvl4(group_b_swing_pins[15:8]);
  wire [1:0] vb0 = lvl4(group_b_swing_pins[7:0]);
  wire [1:0] rxd_lvl = lvl4(termination_detect_pin);
  wire [1:0] sdt_lvl = lvl4(signal_detect_threshold_pin);
  wire pin_mode = (mode_lvl == `LVL_0); // RQ1
  wire slave_pin = (mode_lvl == `LVL_1); // RQ1
  wire master_pin = !pin_mode && !slave_pin; // RQ1

  reg [4:0] ld_q;
  reg [4:0] ld_d;
  reg [2:0] ld_idx_q;
  reg [2:0] ld_idx_d;
  wire load_ok = master_pin && (ld_q == L_DONE);
  wire slave_eff = slave_pin || load_ok; // RQ22
  // Address inputs: bit 0 eq A, 1 eq B, 2 swing A0, 3 swing B0
  wire [3:0] addr_in = {vb0[1], va0[1], eqb_lvl[1], eqa_lvl[1]}; // RQ7
  wire [7:0] addr_byte = `SLAVE_ADDR_BASE + {3'h0, addr_in, 1'b0}; // RQ24

  // Per-channel setting registers and shared override registers
  reg [2*NCH-1:0] eq_q;
  reg [3*NCH-1:0] swing_q;
  reg [NCH-1:0] term_dis_q;
  reg term_ovr_q;
  reg sdth_ovr_q;
  reg [1:0] term_reg_q;
  reg [1:0] sdth_reg_q;

  // Register writes; power-down never touches these
  always @(posedge sys_clk or negedge rst_b) begin // RQ10
    if (!rst_b) begin
      eq_q <= {NCH{`EQ_DEFAULT}};
      swing_q <= {NCH{`SWING_DEFAULT}};
      term_dis_q <= {NCH{1'b0}};
    end else if (ld_q == L_DATA && ee_valid) begin // RQ21
      eq_q[2*ld_idx_q +: 2] <= ee_data[1:0];
      swing_q[3*ld_idx_q +: 3] <= ee_data[6:4];
      term_dis_q[ld_idx_q] <= ee_data[7];
    end else if (cfg_wr && reg_enable && slave_eff) begin // RQ6
      eq_q[2*cfg_chan +: 2] <= cfg_eq; // RQ4
      swing_q[3*cfg_chan +: 3] <= cfg_swing;
      term_dis_q[cfg_chan] <= cfg_term_dis;
    end
  end

  // Overrides latch in slave mode and only release in pin mode
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      term_ovr_q <= 1'b0;
      sdth_ovr_q <= 1'b0;
      term_reg_q <= `TERM_AUTO;
      sdth_reg_q <= `SDTH_FROM_F;
    end else if (pin_mode) begin // RQ9
      term_ovr_q <= 1'b0;
      sdth_ovr_q <= 1'b0;
    end else if (slave_eff && reg_enable) begin // RQ8
      if (term_override) begin
        term_ovr_q <= 1'b1;
        term_reg_q <= term_code;
      end
      if (sdth_override) begin
        sdth_ovr_q <= 1'b1;
        sdth_reg_q <= sdth_code;
      end
    end
  end

  reg [1:0] sdth_pin;
  always @* begin // RQ18
    case (sdt_lvl)
      `LVL_0: sdth_pin = `SDTH_FROM_0;
      `LVL_R: sdth_pin = `SDTH_FROM_R;
      `LVL_F: sdth_pin = `SDTH_FROM_F;
      default: sdth_pin = `SDTH_FROM_1;
    endcase
  end
  // Pin level order 0, R, F, 1 matches codes 00, 01, 10, 11
  wire [1:0] term_eff = term_ovr_q ? term_reg_q : rxd_lvl; // RQ8

  // Receiver-detect sequencing
  localparam PW = 32;
  reg [2:0] dt_q;
  reg [PW-1:0] tick_q;
  reg [7:0] tries_q;
  reg [NCH-1:0] seen_q;
  reg [PW-1:0] pd_cnt_q;
  reg pres_q;
  wire pd_reset = (pd_cnt_q == PDRST_CYC[PW-1:0]); // RQ16
  wire sw_reset = slave_eff && presence_override
                  && (presence_value != pres_q); // RQ17
  wire auto_mode = (term_eff == `TERM_AUTO_LIM) || (term_eff == `TERM_AUTO);
  wire tick = (tick_q == PROBE_CYC[PW-1:0] - 32'h1);

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_cnt_q <= {PW{1'b0}};
      pres_q <= 1'b0;
    end else begin
      pres_q <= presence_value;
      if (!power_down_pin) pd_cnt_q <= {PW{1'b0}};
      else if (!pd_reset) pd_cnt_q <= pd_cnt_q + 32'h1; // RQ16
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dt_q <= D_WAIT;
      tick_q <= {PW{1'b0}};
      tries_q <= 8'h0;
      seen_q <= {NCH{1'b0}};
      rx_probe <= 1'b0;
    end else if (pd_reset || sw_reset) begin // RQ16 RQ17
      dt_q <= D_WAIT;
      tick_q <= {PW{1'b0}};
      tries_q <= 8'h0;
      seen_q <= {NCH{1'b0}};
      rx_probe <= 1'b0;
    end else begin
      rx_probe <= 1'b0;
      case (dt_q)
        D_WAIT: begin
          if (auto_mode && !power_down_pin) begin
            tick_q <= tick ? {PW{1'b0}} : tick_q + 32'h1;
            seen_q <= seen_q | rx_far_end_seen;
            if (&(seen_q | rx_far_end_seen)) begin
              dt_q <= D_DONE;
            end else if (tick) begin
              if (term_eff == `TERM_AUTO_LIM
                  && tries_q == PROBE_TRIES[7:0]) begin // RQ12
                dt_q <= D_STOP;
              end else begin
                rx_probe <= 1'b1; // RQ13
                tries_q <= tries_q + 8'h1;
              end
            end
          end
        end
        D_DONE: dt_q <= D_DONE;
        D_STOP: dt_q <= D_STOP;
        default: dt_q <= D_WAIT;
      endcase
    end
  end

  // EEPROM loader
  always @* begin
    ld_d = ld_q;
    ld_idx_d = ld_idx_q;
    case (ld_q)
      L_IDLE: if (master_pin && !load_permit_b) ld_d = L_HDR; // RQ26
      L_HDR: if (ee_valid) begin
        if (ee_data == `EE_BLANK) ld_d = L_STALL; // RQ23
        else ld_d = L_DATA;
        ld_idx_d = 3'h0;
      end
      L_DATA: if (ee_valid) begin
        if (ld_idx_q == NCH[2:0] - 3'h1) ld_d = L_DONE;
        else ld_idx_d = ld_idx_q + 3'h1;
      end
      L_DONE: ld_d = L_DONE;
      L_STALL: ld_d = L_STALL; // RQ23
      default: ld_d = L_IDLE;
    endcase
    if (!master_pin && ld_q != L_STALL) ld_d = L_IDLE;
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ld_q <= L_IDLE;
      ld_idx_q <= 3'h0;
    end else begin
      ld_q <= ld_d;
      ld_idx_q <= ld_idx_d;
    end
  end

  // Channel controls and status, all registered
  integer i;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      eq_out <= {NCH{`EQ_DEFAULT}};
      swing_out <= {NCH{`SWING_DEFAULT}};
      term_50_en <= {NCH{1'b0}};
      driver_en <= {NCH{1'b0}};
      sdth_out <= `SDTH_FROM_F;
      signal_detect_status <= {NCH{1'b0}};
      slave_addr <= `SLAVE_ADDR_BASE;
      mode_out <= M_PIN;
      ee_req <= 1'b0;
      ee_dev_addr <= `EEPROM_ADDR_BYTE;
      ee_addr <= `EE_HDR_ADDR;
      load_done <= 1'b0;
      bus_master_active <= 1'b0;
      bus_slave_enable <= 1'b0;
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        if (pin_mode) begin // RQ3
          eq_out[2*i +: 2] <= (i < NCH/2) ? eqa_lvl : eqb_lvl;
          swing_out[3*i +: 3] <= (i < NCH/2) ? swing_lvl(va1, va0)
                                             : swing_lvl(vb1, vb0);
        end else begin // RQ5
          eq_out[2*i +: 2] <= eq_q[2*i +: 2];
          swing_out[3*i +: 3] <= swing_q[3*i +: 3];
        end
        if (power_down_pin || (!pin_mode && term_dis_q[i])) // RQ15
          term_50_en[i] <= 1'b0;
        else if (term_eff == `TERM_HIZ) term_50_en[i] <= 1'b0; // RQ11
        else if (term_eff == `TERM_50) term_50_en[i] <= 1'b1; // RQ14
        else term_50_en[i] <= seen_q[i]; // RQ12 RQ13
      end
      driver_en <= {NCH{!power_down_pin}}; // RQ15 RQ19
      sdth_out <= sdth_ovr_q ? sdth_reg_q : sdth_pin; // RQ8
      signal_detect_status <= signal_detect_in; // RQ20
      slave_addr <= addr_byte; // RQ24
      mode_out <= pin_mode ? M_PIN : (slave_eff ? M_SLAVE : M_MASTER);
      ee_req <= (ld_d == L_HDR || ld_d == L_DATA) && !ee_valid;
      ee_dev_addr <= `EEPROM_ADDR_BYTE; // RQ25
      ee_addr <= (ld_d == L_DATA)
                 ? `EE_DATA_BASE + `EE_DEV_STRIDE * {6'h0, addr_in}
                   + {7'h0, ld_idx_d}
                 : `EE_HDR_ADDR; // RQ21
      load_done <= master_pin ? (ld_d == L_DONE) : slave_pin; // RQ26
      bus_master_active <= (ld_d == L_HDR) || (ld_d == L_DATA)
                           || (ld_d == L_STALL); // RQ23
      bus_slave_enable <= (ld_d != L_STALL)
                          && (slave_pin || (master_pin && ld_d == L_DONE)); // RQ22 RQ23
    end
  end

endmodule // repeater_mode_ctl
